// ### common/mem_port_if.sv
// byte access port between the 2-wire slave and the memory map
// assumes mgmt_pkg compiled first
`timescale 1ns/1ps
interface mem_port_if;
   import mgmt_pkg::*;
   byte_t addr;
   byte_t wdata;
   byte_t rdata;
   logic  we;
   logic  re;
   modport link (output addr, output wdata, output we, output re, input rdata);
   modport map  (input addr, input wdata, input we, input re, output rdata);
endinterface : mem_port_if

// ### common/mgmt_cfg.svh
// constants of the module management and status block
// included by the package; needs nothing else
`ifndef MGMT_CFG_SVH
`define MGMT_CFG_SVH

`define CLK_MHZ             200
`define DEV_ADDR            7'h50
`define OFS_STATUS          7'h02
`define BIT_DNR             0
`define OFS_FLAGS           7'h03
`define OFS_EVT             7'h04
`define OFS_MASK_FLAGS      7'h64
`define OFS_MASK_EVT        7'h65
`define OFS_PAGE            7'h7f
`define EVT_INIT_DONE       0
`define MEM_PAGE_LSB        8
`define LOW_PAGE_BYTES      128

`define WB_MEM_ADDR         8'h00
`define WB_MEM_DATA         8'h04
`define WB_IRQ_STAT         8'h08
`define WB_IRQ_MASK         8'h0c
`define WB_STATUS           8'h10
`define IRQ_HOST_WR         0
`define IRQ_MOD_RST         1
`define IRQ_INIT_DONE       2
`define IRQ_BITS            3

`define T_INIT_MS           2000
`define INIT_CYC            (`T_INIT_MS * `CLK_MHZ * 1000)
`define T_RESET_MIN_US      2
`define RESET_MIN_CYC       (`T_RESET_MIN_US * `CLK_MHZ)
`define T_LOW_POWER_US      100
`define LOW_POWER_CYC       (`T_LOW_POWER_US * `CLK_MHZ)
`define T_SELECT_US         100
`define SELECT_CYC          (`T_SELECT_US * `CLK_MHZ)
`define T_IRQ_RELEASE_US    500
`define IRQ_RELEASE_CYC     (`T_IRQ_RELEASE_US * `CLK_MHZ)
`define PIN_LATENCY         8
`define SYNC_RST            5'b11110

`endif

// ### common/mgmt_pkg.sv
// types shared by the management block modules
// assumes mgmt_cfg.svh for numeric constants
`include "mgmt_cfg.svh"
package mgmt_pkg;
   typedef logic [3:0] lane_t;
   typedef logic [7:0] byte_t;
   typedef enum logic [2:0]
   {
      TW_IDLE  = 3'b000,
      TW_ADDR  = 3'b001,
      TW_ACK_A = 3'b011,
      TW_WRITE = 3'b010,
      TW_ACK_W = 3'b110,
      TW_READ  = 3'b111,
      TW_ACK_R = 3'b101
   } tw_state_t;
endpackage : mgmt_pkg

// ### testbench/module_mgmt_status_ctrl_tb.sv
// bench for the management block: Wishbone, 2-wire host, pins
// assumes the design sources and twowire_host
`timescale 1ns/1ps
`include "mgmt_cfg.svh"
module module_mgmt_status_ctrl_tb;
   import mgmt_pkg::*;
   localparam int INIT = 50;
   logic clk_i = 1'h0, rst_i = 1'h1, wb_we_i = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0;
   logic module_reset_n_i = 1'h1, module_select_n_i = 1'h0, low_power_select_i = 1'h0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, r;
   logic [3:0] wb_sel_i = 4'hf;
   lane_t los_i = 4'h0, tx_fault_i = 4'h0;
   logic wb_ack_o, irq_o, scl_i, hsda, sda_oe_o, interrupt_out_n_o, low_power_o, ak, sdo;
   wire sda = hsda & ~sda_oe_o;
   byte_t v;
   int error_cnt = 0, n_checks = 0, k;
   module_mgmt_status_ctrl #(.INIT_CYC(INIT)) DUT (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i,
      .wb_dat_o, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .irq_o, .scl_i,
      .sda_i(sda), .sda_o(sdo), .sda_oe_o, .module_reset_n_i, .module_select_n_i,
      .low_power_select_i, .los_i, .tx_fault_i, .interrupt_out_n_o, .low_power_o);
   twowire_host H (.sda_i(sda), .scl_o(scl_i), .sda_o(hsda));
   always #2.5 clk_i = ~clk_i;
   task automatic chk(input logic [31:0] g, e);
      n_checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("unexpected at %0t: %h vs %h", $time, g, e);
      end
   endtask : chk
   task automatic wb(input byte_t a, input logic w, input logic [31:0] d);
      @(posedge clk_i);
      {wb_adr_i, wb_we_i, wb_dat_i, wb_cyc_i, wb_stb_i} <= {a, w, d, 2'h3};
      // no cycle count assumed; only the watchdog ends a hung access
      while (wb_ack_o !== 1'h1)
         @(posedge clk_i);
      r = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'h0;
   endtask : wb
   task automatic wint(input logic e, input int n);
      for (k = 0; k < n && interrupt_out_n_o !== e; k++)
         @(posedge clk_i);
      chk(interrupt_out_n_o, e);
   endtask : wint
   task automatic tw(input byte_t o, d, input logic rd);
      H.start();
      H.xb(8'ha0, v, ak);
      H.xb(o, v, ak);
      if (rd)
      begin
         H.start();
         H.xb(8'ha1, v, ak);
      end
      H.xb(d, v, ak);
      H.stop();
   endtask : tw
   task automatic t_init();
      wb(`WB_STATUS, 1'h0, 0);
      chk(r[0], 1'h1);
      wint(1'h0, INIT + 20);
      tw(8'h02, 8'hff, 1'h1);
      chk(v[0], 1'h0);
      tw(8'h04, 8'hff, 1'h1);
      chk(v, 8'h01);
      wint(1'h1, 20);
      $display("init done");
   endtask : t_init
   task automatic t_los();
      @(posedge clk_i) los_i <= 4'h4;
      wint(1'h0, 20);
      tw(8'h03, 8'hff, 1'h1);
      chk(v, 8'h04);
      @(posedge clk_i) los_i <= 4'h0;
      tw(8'h03, 8'hff, 1'h1);
      chk(v, 8'h04);
      wint(1'h1, 20);
      tw(8'h64, 8'h04, 1'h0);
      @(posedge clk_i) los_i <= 4'h4;
      @(posedge clk_i) los_i <= 4'h0;
      repeat (20) @(posedge clk_i);
      chk(interrupt_out_n_o, 1'h1);
      tw(8'h64, 8'h00, 1'h0);
      wint(1'h0, 20);
      @(posedge clk_i) tx_fault_i <= 4'h2;
      @(posedge clk_i) tx_fault_i <= 4'h0;
      tw(8'h03, 8'hff, 1'h1);
      chk(v, 8'h24);
      wint(1'h1, 20);
      $display("flags done");
   endtask : t_los
   task automatic t_sel();
      H.start();
      H.xb(8'ha2, v, ak);
      H.stop();
      chk(ak, 1'h0);
      chk(sdo, 1'h0);
      @(posedge clk_i) module_select_n_i <= 1'h1;
      repeat (10) @(posedge clk_i);
      H.start();
      H.xb(8'ha0, v, ak);
      chk(ak, 1'h0);
      @(posedge clk_i) module_select_n_i <= 1'h0;
      $display("select done");
   endtask : t_sel
   task automatic t_wb();
      wb(`WB_IRQ_MASK, 1'h1, 32'h7);
      @(posedge clk_i);
      chk(irq_o, 1'h1);
      wb(`WB_IRQ_STAT, 1'h0, 0);
      chk(r, 32'h5);
      wb(`WB_IRQ_STAT, 1'h0, 0);
      chk(r, 32'h0);
      wb(8'h40, 1'h0, 0);
      chk(r, 32'h0);
      wb(`WB_MEM_ADDR, 1'h1, 32'h0180);
      wb(`WB_MEM_DATA, 1'h1, 32'h5a);
      tw(8'h7f, 8'h01, 1'h0);
      tw(8'h80, 8'hff, 1'h1);
      chk(v, 8'h5a);
      $display("bus done");
   endtask : t_wb
   task automatic t_pins();
      @(posedge clk_i) low_power_select_i <= 1'h1;
      for (k = 0; k < 20 && low_power_o !== 1'h1; k++)
         @(posedge clk_i);
      chk(low_power_o, 1'h1);
      module_reset_n_i <= 1'h0;
      repeat (100) @(posedge clk_i);
      module_reset_n_i <= 1'h1;
      wb(`WB_STATUS, 1'h0, 0);
      chk(r[0], 1'h0);
      module_reset_n_i <= 1'h0;
      repeat (420) @(posedge clk_i);
      module_reset_n_i <= 1'h1;
      wb(`WB_IRQ_STAT, 1'h0, 0);
      chk(r, 32'h3);
      wint(1'h0, INIT + 30);
      $display("pins done");
   endtask : t_pins
   task automatic close_out();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : close_out
   initial
   begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'h0;
      t_init();
      t_los();
      t_sel();
      t_wb();
      t_pins();
      close_out();
   end
   // whole run needs about 20 us
   initial
   begin
      #400us;
      error_cnt++;
      close_out();
   end
endmodule : module_mgmt_status_ctrl_tb

// ### testbench/twowire_host.sv
// 2-wire host model: start, stop, one byte each way
// assumes the bench pulls the open-drain sda wire up
`timescale 1ns/1ps
module twowire_host
   import mgmt_pkg::*;
#(
   parameter realtime TQ = 12.0
)(
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_o
);
   initial
   begin
      scl_o = 1'h1;
      sda_o = 1'h1;
   end
   // quarter bit; keeps every level above the sync need
   task automatic drv(input logic c, d);
      scl_o = c;
      sda_o = d;
      #TQ;
   endtask : drv
   task automatic start();
      drv(scl_o, 1'h1);
      drv(1'h1, 1'h1);
      drv(1'h1, 1'h0);
      drv(1'h0, 1'h0);
   endtask : start
   task automatic stop();
      drv(1'h0, 1'h0);
      drv(1'h1, 1'h0);
      drv(1'h1, 1'h1);
   endtask : stop
   // ninth bit high releases sda for the slave ack or our nack
   task automatic xb(input byte_t tx, output byte_t rx, output logic ack);
      logic [8:0] t;
      logic [8:0] s;
      t = {tx, 1'h1};
      for (int i = 8; i >= 0; i--)
      begin
         drv(1'h0, t[i]);
         drv(1'h1, t[i]);
         s[i] = sda_i;
         drv(1'h1, t[i]);
         drv(1'h0, t[i]);
      end
      rx = s[8:1];
      ack = ~s[0];
   endtask : xb
endmodule : twowire_host

// ### verilog/module_mgmt_status_ctrl.sv
// management memory, interrupt flags and control pins of a four-lane module
// assumes a classic Wishbone master for local firmware and a 2-wire host
//
// Chosen here: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`include "mgmt_cfg.svh"
// Behaviour
// RULE1 - a 128-byte lower page is always addressable and upper pages share the upper window.
// RULE2 - upper pages hold slow content and the page select byte picks the visible one.
// RULE3 - flags and monitors live in the lower page so one read sequence collects an event.
// RULE4 - the 2-wire slave answers only at device address A0 hex.
// RULE5 - after the interrupt line falls the host reads the flag byte to find lane and kind.
// RULE6 - the block is fully functional at most 2000 ms after reset or the reset pin's release.
// RULE7 - a low on the reset pin resets only when it lasts longer than 2 us.
// RULE8 - the 2-wire slave answers within 2000 ms of power-on.
// RULE9 - within 2000 ms the data-not-ready bit 0 of byte 2 clears and the interrupt asserts.
// RULE10 - the low-power select input takes effect within 100 us.
// RULE11 - the interrupt line falls within 200 ms of a triggering condition.
// RULE12 - flags clear on read and the interrupt line releases within 500 us of that read.
// RULE13 - a lane in loss of signal sets its flag and the interrupt within 100 ms.
// RULE14 - the slave answers only while module select is low, within 100 us either way.
// RULE15 - a mask bit blocks or restores its flag's interrupt within 100 ms.
// RULE16 - a flag stays latched until read and sets again if its condition persists.
// RULE17 - the interrupt line stays low while any unmasked latched flag is set.
module module_mgmt_status_ctrl #(
   parameter int          UPPER_PAGES = 4,
   parameter int unsigned INIT_CYC    = `INIT_CYC
)(
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   input  wire logic [7:0]    wb_adr_i,
   input  wire logic [31:0]   wb_dat_i,
   output logic      [31:0]   wb_dat_o,
   input  wire logic [3:0]    wb_sel_i,
   input  wire logic          wb_we_i,
   input  wire logic          wb_cyc_i,
   input  wire logic          wb_stb_i,
   output logic               wb_ack_o,
   output logic               irq_o,
   input  wire logic          scl_i,
   input  wire logic          sda_i,
   output logic               sda_o,
   output logic               sda_oe_o,
   input  wire logic          module_reset_n_i,
   input  wire logic          module_select_n_i,
   input  wire logic          low_power_select_i,
   input  wire mgmt_pkg::lane_t los_i,
   input  wire mgmt_pkg::lane_t tx_fault_i,
   output logic               interrupt_out_n_o,
   output logic               low_power_o
);
   import mgmt_pkg::*;

   localparam int PW        = (UPPER_PAGES > 1) ? $clog2(UPPER_PAGES) : 1;
   localparam int RST_MIN_C = `RESET_MIN_CYC;
   localparam int RCW       = $clog2(RST_MIN_C + 1);

   if (UPPER_PAGES < 1 || UPPER_PAGES > 256)
   begin : g_bad_pages
      $error("UPPER_PAGES must lie in 1..256");
   end
   if (INIT_CYC < 2 || `PIN_LATENCY > `LOW_POWER_CYC || `PIN_LATENCY > `SELECT_CYC)
   begin : g_bad_timing
      $error("timing counts too small for pin latency");
   end

   mem_port_if u_mem ();

   logic [4:0] pins_s;
   logic       scl_s, sda_s, mrst_n_s, sel_n_s, lp_s;

   // control: reset pin filter, initialisation, low power
   logic [RCW-1:0] rst_cnt_q, rst_cnt_d;
   logic           hold_q, hold_d;
   logic [31:0]    init_cnt_q, init_cnt_d;
   logic           dnr_q, dnr_d;
   logic           lp_q, lp_d;
   logic           soft_rst, init_done, tw_en;

   // host-visible flag state
   byte_t flags_q, flags_d;
   byte_t evt_q, evt_d;
   byte_t mask_f_q, mask_f_d;
   byte_t mask_e_q, mask_e_d;
   byte_t page_q, page_d;
   logic  int_n_q, int_n_d;
   byte_t clr_flags, clr_evt;

   // local bus
   logic                 acc;
   logic                 ack_q, ack_d;
   logic [31:0]          dat_q, dat_d;
   logic [15:0]          maddr_q, maddr_d;
   logic [`IRQ_BITS-1:0] istat_q, istat_d;
   logic [`IRQ_BITS-1:0] imask_q, imask_d;
   logic [`IRQ_BITS-1:0] iev;
   logic                 irq_q, irq_d;
   logic                 wb_mem_we;

   byte_t lower_q [`LOW_PAGE_BYTES];
   byte_t upper_q [UPPER_PAGES * `LOW_PAGE_BYTES];

   pin_sync #(
      .W       (5),
      .RST_VAL (`SYNC_RST)
   ) u_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   ({scl_i, sda_i, module_reset_n_i, module_select_n_i, low_power_select_i}),
      .q_o   (pins_s)
   );
   assign {scl_s, sda_s, mrst_n_s, sel_n_s, lp_s} = pins_s;

   twowire_slave u_tw (
      .clk_i    (clk_i),
      .rst_i    (soft_rst),
      .en_i     (tw_en),
      .scl_i    (scl_s),
      .sda_i    (sda_s),
      .sda_oe_o (sda_oe_o),
      .mem      (u_mem.link)
   );

   // overlaid bytes come from registers, not from the array
   function automatic logic is_live(input byte_t a);
      return !a[7] && (a[6:0] == `OFS_STATUS || a[6:0] == `OFS_FLAGS || a[6:0] == `OFS_EVT ||
                       a[6:0] == `OFS_MASK_FLAGS || a[6:0] == `OFS_MASK_EVT || a[6:0] == `OFS_PAGE);
   endfunction : is_live

   function automatic byte_t read_byte(input byte_t a, input byte_t pg);
      byte_t v;
      v = 8'h00;
      if (!a[7])
      begin
         case (a[6:0])
            `OFS_STATUS:     v[`BIT_DNR] = dnr_q; // RULE9
            `OFS_FLAGS:      v = flags_q; // RULE3
            `OFS_EVT:        v = evt_q;
            `OFS_MASK_FLAGS: v = mask_f_q;
            `OFS_MASK_EVT:   v = mask_e_q;
            `OFS_PAGE:       v = page_q;
            default:         v = lower_q[a[6:0]]; // RULE1
         endcase
      end
      else if (pg < UPPER_PAGES)
         v = upper_q[{pg[PW-1:0], a[6:0]}]; // RULE2
      return v;
   endfunction : read_byte

   assign u_mem.rdata = read_byte(u_mem.addr, page_q);

   always_comb
   begin
      rst_cnt_d  = rst_cnt_q;
      hold_d     = hold_q;
      init_cnt_d = init_cnt_q;
      dnr_d      = dnr_q;
      init_done  = 1'b0;
      lp_d       = lp_s; // RULE10
      if (mrst_n_s)
      begin
         rst_cnt_d = '0;
         hold_d    = 1'b0;
      end
      else if (rst_cnt_q != RCW'(RST_MIN_C))
         rst_cnt_d = rst_cnt_q + RCW'(1);
      else
         hold_d = 1'b1; // RULE7
      if (hold_q)
      begin
         init_cnt_d = '0;
         dnr_d      = 1'b1; // RULE6
      end
      else if (dnr_q)
      begin
         if (init_cnt_q == INIT_CYC - 1)
         begin
            dnr_d     = 1'b0; // RULE9
            init_done = 1'b1;
         end
         else
            init_cnt_d = init_cnt_q + 32'h1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rst_cnt_q  <= '0;
         hold_q     <= 1'b0;
         init_cnt_q <= 32'h0;
         dnr_q      <= 1'b1;
         lp_q       <= 1'b0;
      end
      else
      begin
         rst_cnt_q  <= rst_cnt_d;
         hold_q     <= hold_d;
         init_cnt_q <= init_cnt_d;
         dnr_q      <= dnr_d;
         lp_q       <= lp_d;
      end
   end

   assign soft_rst = rst_i | hold_q;
   assign tw_en    = ~sel_n_s; // RULE14 RULE8

   always_comb
   begin
      clr_flags = (u_mem.re && u_mem.addr == {1'b0, `OFS_FLAGS}) ? flags_q : 8'h00; // RULE12
      clr_evt   = (u_mem.re && u_mem.addr == {1'b0, `OFS_EVT}) ? evt_q : 8'h00;
      // set beats clear, a persisting condition latches again
      flags_d   = (flags_q & ~clr_flags) | {tx_fault_i, los_i}; // RULE13 RULE16
      evt_d     = evt_q & ~clr_evt;
      evt_d[`EVT_INIT_DONE] = evt_d[`EVT_INIT_DONE] | init_done; // RULE9
      mask_f_d  = mask_f_q;
      mask_e_d  = mask_e_q;
      page_d    = page_q;
      if (u_mem.we && !u_mem.addr[7])
      begin
         case (u_mem.addr[6:0])
            `OFS_MASK_FLAGS: mask_f_d = u_mem.wdata; // RULE15
            `OFS_MASK_EVT:   mask_e_d = u_mem.wdata;
            `OFS_PAGE:       page_d   = u_mem.wdata; // RULE2
            default: ;
         endcase
      end
      int_n_d = ~(|(flags_q & ~mask_f_q) | |(evt_q & ~mask_e_q)); // RULE11 RULE17 RULE15
   end

   always_ff @(posedge clk_i)
   begin
      if (soft_rst)
      begin
         flags_q  <= 8'h00;
         evt_q    <= 8'h00;
         mask_f_q <= 8'h00;
         mask_e_q <= 8'h00;
         page_q   <= 8'h00;
         int_n_q  <= 1'b1;
      end
      else
      begin
         flags_q  <= flags_d;
         evt_q    <= evt_d;
         mask_f_q <= mask_f_d;
         mask_e_q <= mask_e_d;
         page_q   <= page_d;
         int_n_q  <= int_n_d;
      end
   end

   // local bus: registered answer one cycle after the request
   assign acc       = wb_cyc_i & wb_stb_i & ~ack_q;
   assign wb_mem_we = acc & wb_we_i & wb_sel_i[0] & (wb_adr_i == `WB_MEM_DATA);

   always_comb
   begin
      ack_d   = acc;
      dat_d   = dat_q;
      maddr_d = maddr_q;
      imask_d = imask_q;
      iev     = '0;
      iev[`IRQ_HOST_WR]   = u_mem.we;
      iev[`IRQ_MOD_RST]   = hold_d & ~hold_q;
      iev[`IRQ_INIT_DONE] = init_done;
      istat_d = istat_q | iev;
      if (acc)
      begin
         dat_d = 32'h0;
         case (wb_adr_i)
            `WB_MEM_ADDR: dat_d[15:0] = maddr_q;
            `WB_MEM_DATA: dat_d[7:0]  = read_byte(maddr_q[7:0], maddr_q[15:`MEM_PAGE_LSB]);
            `WB_IRQ_MASK: dat_d[`IRQ_BITS-1:0] = imask_q;
            `WB_STATUS:   dat_d[3:0]  = {int_n_q, ~sel_n_s, lp_q, dnr_q};
            `WB_IRQ_STAT:
            begin
               dat_d[`IRQ_BITS-1:0] = istat_q;
               if (!wb_we_i)
                  istat_d = iev;
            end
            default: ;
         endcase
         if (wb_we_i && wb_adr_i == `WB_MEM_ADDR)
         begin
            if (wb_sel_i[0])
               maddr_d[7:0] = wb_dat_i[7:0];
            if (wb_sel_i[1])
               maddr_d[15:8] = wb_dat_i[15:8];
         end
         if (wb_we_i && wb_adr_i == `WB_IRQ_MASK && wb_sel_i[0])
            imask_d = wb_dat_i[`IRQ_BITS-1:0];
      end
      irq_d = |(istat_q & imask_q);
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_q   <= 1'b0;
         dat_q   <= 32'h0;
         maddr_q <= 16'h0;
         istat_q <= '0;
         imask_q <= '0;
         irq_q   <= 1'b0;
      end
      else
      begin
         ack_q   <= ack_d;
         dat_q   <= dat_d;
         maddr_q <= maddr_d;
         istat_q <= istat_d;
         imask_q <= imask_d;
         irq_q   <= irq_d;
      end
   end

   // array contents are not reset; host write wins a same-cycle collision
   always_ff @(posedge clk_i)
   begin
      if (wb_mem_we && !maddr_q[7] && !is_live(maddr_q[7:0]))
         lower_q[maddr_q[6:0]] <= wb_dat_i[7:0];
      else if (wb_mem_we && maddr_q[7] && maddr_q[15:8] < UPPER_PAGES)
         upper_q[{maddr_q[8 +: PW], maddr_q[6:0]}] <= wb_dat_i[7:0];
      if (u_mem.we && !u_mem.addr[7] && !is_live(u_mem.addr))
         lower_q[u_mem.addr[6:0]] <= u_mem.wdata; // RULE1
      else if (u_mem.we && u_mem.addr[7] && page_q < UPPER_PAGES)
         upper_q[{page_q[PW-1:0], u_mem.addr[6:0]}] <= u_mem.wdata; // RULE2
   end

   assign wb_dat_o          = dat_q;
   assign wb_ack_o          = ack_q;
   assign irq_o             = irq_q;
   assign sda_o             = 1'b0;
   assign interrupt_out_n_o = int_n_q;
   assign low_power_o       = lp_q;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_los_flag;
      !hold_q && los_i != 4'h0 |=> (flags_q[3:0] & $past(los_i)) == $past(los_i);
   endproperty
   a_los_flag: assert property (p_los_flag) else $error("loss of signal flag not set"); // RULE13

   property p_latch;
      !hold_q && flags_q != 8'h00 && clr_flags == 8'h00 |=> (flags_q & $past(flags_q)) == $past(flags_q);
   endproperty
   a_latch: assert property (p_latch) else $error("latched flag lost without read"); // RULE16

   property p_clear;
      !hold_q && clr_flags != 8'h00 && {tx_fault_i, los_i} == 8'h00 |=> flags_q == 8'h00;
   endproperty
   a_clear: assert property (p_clear) else $error("flag not cleared by read"); // RULE12

   property p_irq_on;
      !hold_q && (flags_q & ~mask_f_q) != 8'h00 |=> !interrupt_out_n_o;
   endproperty
   a_irq_on: assert property (p_irq_on) else $error("interrupt not asserted"); // RULE11

   property p_irq_off;
      !hold_q && (flags_q & ~mask_f_q) == 8'h00 && (evt_q & ~mask_e_q) == 8'h00 |=> interrupt_out_n_o;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("interrupt held without cause"); // RULE17

   property p_ready;
      $fell(dnr_q) && !mask_e_q[`EVT_INIT_DONE] |-> evt_q[`EVT_INIT_DONE] ##1 !interrupt_out_n_o;
   endproperty
   a_ready: assert property (p_ready) else $error("ready event missing"); // RULE9

   property p_init_time;
      $fell(dnr_q) |-> $past(init_cnt_q) == INIT_CYC - 1;
   endproperty
   a_init_time: assert property (p_init_time) else $error("init time wrong"); // RULE6

   property p_reset_min;
      $rose(hold_q) |-> $past(rst_cnt_q) == RCW'(RST_MIN_C) && !$past(mrst_n_s);
   endproperty
   a_reset_min: assert property (p_reset_min) else $error("short reset pulse accepted"); // RULE7

   property p_lp;
      low_power_select_i [*7] |-> low_power_o;
   endproperty
   a_lp: assert property (p_lp) else $error("low power not entered"); // RULE10

   property p_select;
      module_select_n_i [*7] |-> !sda_oe_o;
   endproperty
   a_select: assert property (p_select) else $error("answered while deselected"); // RULE14

   c_flag_read: cover property (clr_flags != 8'h00);
   c_ready:     cover property ($fell(dnr_q));
   c_mod_rst:   cover property ($rose(hold_q));
   c_irq_read:  cover property (acc && !wb_we_i && wb_adr_i == `WB_IRQ_STAT && istat_q != '0);
endmodule : module_mgmt_status_ctrl

// ### verilog/pin_sync.sv
// three-stage synchroniser for asynchronous pins
// a change is accepted once stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
   parameter int           W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
)(
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] out_q;
   logic [W-1:0] out_d;

   for (genvar i = 0; i < W; i++)
   begin : g_bit
      always_comb
      begin
         out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s1_q  <= RST_VAL;
         s2_q  <= RST_VAL;
         s3_q  <= RST_VAL;
         out_q <= RST_VAL;
      end
      else
      begin
         s1_q  <= d_i;
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         out_q <= out_d;
      end
   end

   // taken as soon as stages agree: one cycle less latency on the 48 ns link
   assign q_o = out_d;
endmodule : pin_sync

// ### verilog/twowire_slave.sv
// 2-wire serial slave: device address, offset pointer, byte read and write
// assumes scl/sda already synchronised; sda is open drain, low only
`timescale 1ns/1ps
`include "mgmt_cfg.svh"
module twowire_slave
   import mgmt_pkg::*;
(
   input  wire logic  clk_i,
   input  wire logic  rst_i,
   input  wire logic  en_i,
   input  wire logic  scl_i,
   input  wire logic  sda_i,
   output logic       sda_oe_o,
   mem_port_if.link   mem
);
   tw_state_t  state_q, state_d;
   logic [2:0] cnt_q, cnt_d;
   byte_t      sh_q, sh_d;
   byte_t      ptr_q, ptr_d;
   logic       first_q, first_d;
   logic       rd_q, rd_d;
   logic       drive_q, drive_d;
   logic       scl_p_q;
   logic       sda_p_q;
   logic       rise, fall, start, stop;
   byte_t      in_byte;

   assign rise    = scl_i & ~scl_p_q;
   assign fall    = ~scl_i & scl_p_q;
   assign start   = scl_i & scl_p_q & sda_p_q & ~sda_i;
   assign stop    = scl_i & scl_p_q & ~sda_p_q & sda_i;
   assign in_byte = {sh_q[6:0], sda_i};

   always_comb
   begin
      state_d   = state_q;
      cnt_d     = cnt_q;
      sh_d      = sh_q;
      ptr_d     = ptr_q;
      first_d   = first_q;
      rd_d      = rd_q;
      drive_d   = drive_q;
      mem.we    = 1'b0;
      mem.re    = 1'b0;
      mem.addr  = ptr_q;
      mem.wdata = in_byte;
      if (!en_i || stop)
      begin
         state_d = TW_IDLE;
         drive_d = 1'b0;
      end
      else if (start)
      begin
         state_d = TW_ADDR;
         cnt_d   = 3'h0;
         drive_d = 1'b0;
      end
      else
      begin
         case (state_q)
            TW_ADDR:
               if (rise)
               begin
                  sh_d  = in_byte;
                  cnt_d = cnt_q + 3'h1;
                  rd_d  = sda_i;
                  first_d = 1'b1;
                  if (cnt_q == 3'h7)
                     state_d = (in_byte[7:1] == `DEV_ADDR) ? TW_ACK_A : TW_IDLE; // RULE4
               end
            TW_ACK_A, TW_ACK_W:
               if (fall)
               begin
                  drive_d = ~drive_q;
                  cnt_d   = 3'h0;
                  if (drive_q && rd_q && state_q == TW_ACK_A)
                  begin
                     mem.re  = 1'b1;
                     sh_d    = mem.rdata;
                     ptr_d   = ptr_q + 8'h01;
                     drive_d = ~mem.rdata[7];
                     state_d = TW_READ;
                  end
                  else if (drive_q)
                     state_d = TW_WRITE;
               end
            TW_WRITE:
               if (rise)
               begin
                  sh_d  = in_byte;
                  cnt_d = cnt_q + 3'h1;
                  if (cnt_q == 3'h7)
                  begin
                     state_d = TW_ACK_W;
                     first_d = 1'b0;
                     if (first_q)
                        ptr_d = in_byte;
                     else
                     begin
                        mem.we = 1'b1;
                        ptr_d  = ptr_q + 8'h01;
                     end
                  end
               end
            TW_READ:
               if (fall)
               begin
                  cnt_d   = cnt_q + 3'h1;
                  sh_d    = {sh_q[6:0], 1'b0};
                  drive_d = (cnt_q == 3'h7) ? 1'b0 : ~sh_q[6];
                  if (cnt_q == 3'h7)
                     state_d = TW_ACK_R;
               end
            TW_ACK_R:
               if (rise && sda_i)
                  state_d = TW_IDLE;
               else if (fall)
               begin
                  mem.re  = 1'b1;
                  sh_d    = mem.rdata;
                  ptr_d   = ptr_q + 8'h01;
                  drive_d = ~mem.rdata[7];
                  cnt_d   = 3'h0;
                  state_d = TW_READ;
               end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_q <= TW_IDLE;
         cnt_q   <= 3'h0;
         sh_q    <= 8'h00;
         ptr_q   <= 8'h00;
         first_q <= 1'b0;
         rd_q    <= 1'b0;
         drive_q <= 1'b0;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end
      else
      begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         sh_q    <= sh_d;
         ptr_q   <= ptr_d;
         first_q <= first_d;
         rd_q    <= rd_d;
         drive_q <= drive_d;
         scl_p_q <= scl_i;
         sda_p_q <= sda_i;
      end
   end

   assign sda_oe_o = drive_q;
endmodule : twowire_slave
